/* File: hw/health_monitor_pkg.sv */
// constants, register map and types for the processor and fan health monitor
package health_monitor_pkg;
  localparam int num_cpu = 4;
  localparam int num_fan = 4;
  localparam int num_dom = 2;
  localparam int clk_mhz = 100;
  // throttle measurement window in ms, and in cycles
  localparam int throttle_window_ms = 5800;
  localparam longint throttle_window_cycles = longint'(throttle_window_ms) * clk_mhz * 1000;
  localparam logic [6:0] throttle_limit_pct_rst = 7'h32;
  localparam logic [7:0] poller_addr_rst = 8'h4c;
  localparam logic [7:0] sleep_speed_rst = 8'h33;
  localparam logic [7:0] boost_speed_rst = 8'hff;
  localparam logic [7:0] nominal_speed_rst = 8'h80;
  // register byte offsets
  localparam logic [7:0] off_ctrl = 8'h00;
  localparam logic [7:0] off_cpu_status = 8'h04;
  localparam logic [7:0] off_cpu_cmd = 8'h08;
  localparam logic [7:0] off_thermal = 8'h0c;
  localparam logic [7:0] off_throttle = 8'h10;
  localparam logic [7:0] off_throttle_limit = 8'h14;
  localparam logic [7:0] off_fan_status = 8'h18;
  localparam logic [7:0] off_fan_cfg = 8'h1c;
  localparam logic [7:0] off_fan_force = 8'h20;
  localparam logic [7:0] off_fan_speed = 8'h24;
  // cpu status field positions within each 8-bit lane
  localparam int st_present = 0;
  localparam int st_trip = 1;
  localparam int st_internal_error_flag = 2;
  localparam int st_disabled = 3;
  localparam int st_trip_hist = 4;
  localparam int st_armed = 5;
  // ctrl register bits
  localparam int ctl_s1 = 0;
  localparam int ctl_sleep_en = 1;
  localparam int ctl_cover_missing = 2;
  localparam int ctl_poll = 3;
  typedef enum logic [1:0] {
    dom_nominal = 2'b00,
    dom_sleep = 2'b01,
    dom_boost = 2'b11
  } dom_state_t;
  typedef enum logic [1:0] {
    poll_idle = 2'b00,
    poll_req = 2'b01,
    poll_wait = 2'b11
  } poll_state_t;
endpackage

/* File: hw/health_monitor.sv */
// processor status sensors, throttle duty monitor and fan domain control
`timescale 1ns/1ps
// Functional notes
// - non-presence status offsets are sticky until an explicit clear
// - rearm or retest command clears sticky offsets and rearms the sensor
// - ac power cycle clears persistent bits only for an empty socket
// - dc power-on and system reset neither rearm nor clear sticky offsets
// - empty socket sets disable bit and clears all other status bits except the armed bit
// - presence starts deasserted, then sensed; refreshed at dc power-on and reset
// - per-cpu trip history since last rearm or retest
// - on a trip, all cpus polled before power-down, tripped ones flagged
// - internal-error input reflected onto the internal-error offset
// - regulator overtemperature asserts the matching throttle signal one-to-one
// - relative thermal reading never positive, zero at and above throttle point
// - thermal readings fetched from a poller device over an smbus request port
// - throttle percentage measured over a 5.8 second window
// - only an upper-critical throttle threshold, default 50 percent
// - cpu-missing starts deasserted, sensed each dc power-on, alert per fault
// - cpu-missing clears only after ac off, cpu insertion and ac on
// - each fan domain is sleep, nominal or boost with configured speeds
// - manual force command overrides every other fan speed control
// - boost wins on critical or missing fan, critical temp, or cover missing
// - sleep only without boost, in s1, and with sleep enabled
// - absent hot-swap fan makes its sensor unavailable and boosts its domains
// - fan reinsertion or power-cycle/reset rearms speed sensor, clears failure
module health_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] cpu_present,
  input wire logic [3:0] cpu_trip,
  input wire logic [3:0] internal_error_flag,
  input wire logic [3:0] regulator_overtemp_signal,
  input wire logic [3:0] cpu_throttle_in,
  input wire logic ac_power_on,
  input wire logic dc_power_on,
  input wire logic system_reset,
  input wire logic trip_event,
  output logic power_down_ok,
  output logic [3:0] cpu_throttle_out,
  output logic cpu_missing_alert,
  output logic poll_req_valid,
  output logic [7:0] poll_addr,
  output logic [1:0] poll_cpu,
  input wire logic poll_ack,
  input wire logic [7:0] poll_data,
  input wire logic [3:0] fan_present,
  input wire logic [3:0] fan_fault,
  input wire logic [3:0] temp_critical,
  input wire logic [7:0] fan_policy_speed0,
  input wire logic [7:0] fan_policy_speed1,
  output logic [7:0] fan_speed0,
  output logic [7:0] fan_speed1
);
  localparam int wbits = 40;
  // short local names for package constants, nothing imported
  localparam longint throttle_window_cycles = health_monitor_pkg::throttle_window_cycles;
  localparam logic [7:0] off_ctrl = health_monitor_pkg::off_ctrl;
  localparam logic [7:0] off_cpu_status = health_monitor_pkg::off_cpu_status;
  localparam logic [7:0] off_cpu_cmd = health_monitor_pkg::off_cpu_cmd;
  localparam logic [7:0] off_thermal = health_monitor_pkg::off_thermal;
  localparam logic [7:0] off_throttle = health_monitor_pkg::off_throttle;
  localparam logic [7:0] off_throttle_limit = health_monitor_pkg::off_throttle_limit;
  localparam logic [7:0] off_fan_status = health_monitor_pkg::off_fan_status;
  localparam logic [7:0] off_fan_cfg = health_monitor_pkg::off_fan_cfg;
  localparam logic [7:0] off_fan_force = health_monitor_pkg::off_fan_force;
  localparam logic [7:0] off_fan_speed = health_monitor_pkg::off_fan_speed;
  localparam int st_present = health_monitor_pkg::st_present;
  localparam int st_trip = health_monitor_pkg::st_trip;
  localparam int st_internal_error_flag = health_monitor_pkg::st_internal_error_flag;
  localparam int st_disabled = health_monitor_pkg::st_disabled;
  localparam int st_trip_hist = health_monitor_pkg::st_trip_hist;
  localparam int st_armed = health_monitor_pkg::st_armed;
  localparam int ctl_s1 = health_monitor_pkg::ctl_s1;
  localparam int ctl_sleep_en = health_monitor_pkg::ctl_sleep_en;
  localparam int ctl_cover_missing = health_monitor_pkg::ctl_cover_missing;
  localparam int ctl_poll = health_monitor_pkg::ctl_poll;
  localparam logic [1:0] dom_nominal = health_monitor_pkg::dom_nominal;
  localparam logic [1:0] dom_sleep = health_monitor_pkg::dom_sleep;
  localparam logic [1:0] dom_boost = health_monitor_pkg::dom_boost;
  localparam logic [1:0] poll_idle = health_monitor_pkg::poll_idle;
  localparam logic [1:0] poll_req = health_monitor_pkg::poll_req;
  localparam logic [1:0] poll_wait = health_monitor_pkg::poll_wait;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] ctrl;
    logic [3:0][7:0] cpu_st;
    logic [3:0][7:0] thermal;
    logic [3:0][6:0] pct;
    logic [3:0][wbits-1:0] hi_cnt;
    logic [wbits-1:0] win_cnt;
    logic [6:0] limit;
    logic [3:0] over_limit;
    logic cpu_missing;
    logic missing_alert;
    logic ac_q;
    logic dc_q;
    logic rst_q;
    logic [3:0] fan_fail;
    logic [3:0] fan_prs_q;
    logic [3:0] fan_map0;
    logic [3:0] fan_map1;
    logic [7:0] sleep_spd;
    logic [7:0] boost_spd;
    logic [1:0] force_en;
    logic [1:0][7:0] force_val;
    logic [1:0][7:0] speed;
    logic [1:0][1:0] dom;
    logic [1:0] pstate;
    logic [1:0] pcpu;
    logic [7:0] paddr_q;
    logic [3:0] throttle;
    logic trip_pend;
    logic pdown_ok;
    logic init_done;
  } state_t;

  state_t q, d;
  logic wr, rd, dc_rise, rst_rise, ac_rise;
  logic [3:0] boost_c;
  logic [1:0][7:0] pol;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign dc_rise = dc_power_on && !q.dc_q;
  assign rst_rise = system_reset && !q.rst_q;
  assign ac_rise = ac_power_on && !q.ac_q;
  assign pol[0] = fan_policy_speed0;
  assign pol[1] = fan_policy_speed1;

  always_comb begin
    logic [31:0] rdv;
    logic hit;
    logic [1:0] bst;
    rdv = 32'h0000_0000;
    hit = 1'b1;
    bst = 2'b00;
    d = q;
    d.pready = 1'b0;
    d.ac_q = ac_power_on;
    d.dc_q = dc_power_on;
    d.rst_q = system_reset;
    d.fan_prs_q = fan_present;
    // first cycle after reset: sense presence once, like a power-on
    d.init_done = 1'b1;
    d.throttle = cpu_throttle_in | regulator_overtemp_signal;
    for (int i = 0; i < 4; i++) begin
      if (!cpu_present[i]) begin
        d.cpu_st[i] = 8'h00;
        d.cpu_st[i][st_disabled] = 1'b1;
        d.cpu_st[i][st_armed] = q.cpu_st[i][st_armed];
      end else begin
        if (internal_error_flag[i])
          d.cpu_st[i][st_internal_error_flag] = 1'b1;
        if (q.trip_pend && cpu_trip[i]) begin
          d.cpu_st[i][st_trip] = 1'b1;
          d.cpu_st[i][st_trip_hist] = 1'b1;
        end
        d.cpu_st[i][st_disabled] = 1'b0;
      end
      // presence only refreshed at dc power-on and reset, sticky bits left alone
      if (!q.init_done || dc_rise || rst_rise)
        d.cpu_st[i][st_present] = cpu_present[i];
      if (ac_rise && !cpu_present[i])
        d.cpu_st[i] = 8'h08;
    end
    // throttle duty counting
    if (q.win_cnt == wbits'(throttle_window_cycles - 1)) begin
      d.win_cnt = '0;
      for (int i = 0; i < 4; i++) begin
        d.pct[i] = 7'((q.hi_cnt[i] * 100) / wbits'(throttle_window_cycles));
        d.over_limit[i] = d.pct[i] >= q.limit;
        d.hi_cnt[i] = '0;
      end
    end else begin
      d.win_cnt = q.win_cnt + 1'b1;
      for (int i = 0; i < 4; i++)
        if (q.throttle[i])
          d.hi_cnt[i] = q.hi_cnt[i] + 1'b1;
    end
    // trip polling: latch the trip, flag tripped cpus, then release power-down
    d.pdown_ok = 1'b0;
    if (trip_event && !q.trip_pend)
      d.trip_pend = 1'b1;
    else if (q.trip_pend) begin
      d.trip_pend = 1'b0;
      d.pdown_ok = 1'b1;
    end
    // cpu missing, sampled on dc power-on attempts
    d.missing_alert = 1'b0;
    if ((!q.init_done || dc_rise) && cpu_present == 4'h0) begin
      d.cpu_missing = 1'b1;
      d.missing_alert = 1'b1;
    end else if (ac_rise && cpu_present != 4'h0)
      d.cpu_missing = 1'b0;
    // poller over smbus
    case (q.pstate)
      poll_idle: begin
        if (q.ctrl[ctl_poll])
          d.pstate = poll_req;
      end
      poll_req: d.pstate = poll_wait;
      poll_wait: begin
        if (poll_ack) begin
          // positive readings would be above the trip point; clamp to zero
          d.thermal[q.pcpu] = poll_data[7] ? poll_data : 8'h00;
          d.pcpu = q.pcpu + 1'b1;
          d.pstate = poll_idle;
        end
      end
      default: d.pstate = poll_idle;
    endcase
    // fan failure tracking
    for (int f = 0; f < 4; f++) begin
      if (fan_fault[f] && fan_present[f])
        d.fan_fail[f] = 1'b1;
      if ((fan_present[f] && !q.fan_prs_q[f]) || dc_rise || rst_rise)
        d.fan_fail[f] = fan_fault[f] && fan_present[f];
    end
    boost_c = q.fan_fail | ~fan_present;
    bst[0] = |(boost_c & q.fan_map0) || |temp_critical || q.ctrl[ctl_cover_missing];
    bst[1] = |(boost_c & q.fan_map1) || |temp_critical || q.ctrl[ctl_cover_missing];
    for (int k = 0; k < 2; k++) begin
      if (bst[k]) begin
        d.dom[k] = dom_boost;
        d.speed[k] = q.boost_spd;
      end else if (q.ctrl[ctl_s1] && q.ctrl[ctl_sleep_en]) begin
        d.dom[k] = dom_sleep;
        d.speed[k] = q.sleep_spd;
      end else begin
        d.dom[k] = dom_nominal;
        d.speed[k] = pol[k];
      end
      if (q.force_en[k])
        d.speed[k] = q.force_val[k];
    end
    // apb slave, zero wait: answer in the access cycle's next edge
    if (psel && !penable) begin
      d.pready = 1'b1;
      d.pslverr = 1'b0;
      if (paddr == off_ctrl)
        rdv = {28'h0, q.ctrl};
      else if (paddr == off_cpu_status)
        rdv = q.cpu_st;
      else if (paddr == off_cpu_cmd)
        rdv = {31'h0, q.cpu_missing};
      else if (paddr == off_thermal)
        rdv = q.thermal;
      else if (paddr == off_throttle)
        // top lane shares over-limit flags: only low nibble of cpu3 percent fits
        rdv = {q.over_limit, q.pct[3][3:0], 1'b0, q.pct[2], 1'b0, q.pct[1], 1'b0, q.pct[0]};
      else if (paddr == off_throttle_limit)
        rdv = {25'h0, q.limit};
      else if (paddr == off_fan_status)
        rdv = {6'h0, q.dom[1], 6'h0, q.dom[0], 4'h0, ~fan_present, 4'h0, q.fan_fail};
      else if (paddr == off_fan_cfg)
        rdv = {q.boost_spd, q.sleep_spd, q.fan_map1, q.fan_map0};
      else if (paddr == off_fan_force)
        rdv = {14'h0, q.force_en, q.force_val[1], q.force_val[0]};
      else if (paddr == off_fan_speed)
        rdv = {16'h0, q.speed[1], q.speed[0]};
      else
        hit = 1'b0;
      d.prdata = pwrite ? 32'h0 : rdv;
      d.pslverr = !hit;
    end
    if (wr && q.pready && !q.pslverr) begin
      if (paddr == off_ctrl && pstrb[0])
        d.ctrl = pwdata[3:0];
      else if (paddr == off_cpu_cmd && pstrb[0]) begin
        for (int i = 0; i < 4; i++)
          if (pwdata[i] && cpu_present[i]) begin
            // hardware set on the same cycle still wins
            d.cpu_st[i][st_trip] = q.trip_pend && cpu_trip[i];
            d.cpu_st[i][st_trip_hist] = q.trip_pend && cpu_trip[i];
            d.cpu_st[i][st_internal_error_flag] = internal_error_flag[i];
            d.cpu_st[i][st_armed] = 1'b1;
          end
      end else if (paddr == off_throttle_limit && pstrb[0])
        d.limit = pwdata[6:0];
      else if (paddr == off_fan_cfg) begin
        if (pstrb[0])
          d.fan_map0 = pwdata[3:0];
        if (pstrb[1])
          d.fan_map1 = pwdata[11:8];
        if (pstrb[2])
          d.sleep_spd = pwdata[23:16];
        if (pstrb[3])
          d.boost_spd = pwdata[31:24];
      end else if (paddr == off_fan_force) begin
        if (pstrb[0])
          d.force_val[0] = pwdata[7:0];
        if (pstrb[1])
          d.force_val[1] = pwdata[15:8];
        if (pstrb[2])
          d.force_en = pwdata[17:16];
      end
    end
    if (!(psel && penable) && q.pready)
      d.pready = 1'b0;
    if (psel && penable && q.pready)
      d.pready = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.limit <= health_monitor_pkg::throttle_limit_pct_rst;
      q.sleep_spd <= health_monitor_pkg::sleep_speed_rst;
      q.boost_spd <= health_monitor_pkg::boost_speed_rst;
      q.fan_map0 <= 4'h3;
      q.fan_map1 <= 4'hc;
      q.fan_prs_q <= 4'hf;
      q.speed <= {health_monitor_pkg::nominal_speed_rst, health_monitor_pkg::nominal_speed_rst};
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign power_down_ok = q.pdown_ok;
  assign cpu_throttle_out = q.throttle;
  assign cpu_missing_alert = q.missing_alert;
  assign poll_req_valid = q.pstate == poll_req;
  assign poll_addr = health_monitor_pkg::poller_addr_rst;
  assign poll_cpu = q.pcpu;
  assign fan_speed0 = q.speed[0];
  assign fan_speed1 = q.speed[1];
endmodule

/* File: testbench/hm_checker.sv */
// port-level assertions for the health monitor
`timescale 1ns/1ps
module hm_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trip_event,
  input wire logic power_down_ok,
  input wire logic [3:0] regulator_overtemp_signal,
  input wire logic [3:0] cpu_throttle_out,
  input wire logic dc_power_on,
  input wire logic [3:0] cpu_present,
  input wire logic cpu_missing_alert,
  input wire logic poll_req_valid,
  input wire logic [7:0] poll_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_timing:
    assert property (psel && !penable |=> pready) else $error("pready late");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("pready too long");
  chk_err_unmapped:
    assert property (psel && !penable && paddr > 8'h24 |=> pslverr) else $error("no pslverr");
  chk_vrd_throttle:
    assert property ((regulator_overtemp_signal & ~cpu_throttle_out) != 4'h0 |=>
      (cpu_throttle_out & $past(regulator_overtemp_signal)) == $past(regulator_overtemp_signal))
      else $error("throttle not following overtemp");
  chk_trip_done:
    assert property ($rose(trip_event) |-> ##[1:3] power_down_ok) else $error("no power down");
  chk_pd_pulse:
    assert property (power_down_ok |=> !power_down_ok) else $error("power down held");
  chk_miss_alert:
    assert property ($rose(dc_power_on) && cpu_present == 4'h0 |-> ##[1:3] cpu_missing_alert)
      else $error("no missing alert");
  chk_alert_cause:
    assert property (cpu_missing_alert |-> cpu_present == 4'h0) else $error("false alert");
  chk_poll_addr:
    assert property (poll_req_valid |-> poll_addr == 8'h4c) else $error("poll address");
  chk_poll_pulse:
    assert property (poll_req_valid |=> !poll_req_valid) else $error("poll request held");
endmodule
bind health_monitor hm_checker chk (.*);

/* File: testbench/peci_poller_model.sv */
// behavioural poller device answering thermal read requests
`timescale 1ns/1ps
module peci_poller_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic poll_req_valid,
  input wire logic [1:0] poll_cpu,
  output logic poll_ack,
  output logic [7:0] poll_data
);
  logic [1:0] c;
  // higher sockets answer slower; data toggles outside ack so stale use shows
  initial begin
    poll_ack = 0;
    poll_data = 8'h5a;
    forever begin
      @(posedge pclk);
      if (poll_req_valid === 1'b1 && presetn === 1'b1) begin
        c = poll_cpu;
        repeat (c) @(posedge pclk);
        poll_ack <= 1;
        poll_data <= c[0] ? 8'hf0 : 8'h05;
      end else begin
        poll_ack <= 0;
        poll_data <= ~poll_data;
      end
    end
  end
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the health monitor
`timescale 1ns/1ps
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, power_down_ok, cpu_missing_alert, poll_req_valid, poll_ack;
  logic [3:0] cpu_present = 4'h7, cpu_trip = 4'h0, internal_error_flag = 4'h0;
  logic [3:0] regulator_overtemp_signal = 4'h0, cpu_throttle_in = 4'h0, cpu_throttle_out;
  logic ac_power_on = 1, dc_power_on = 0, system_reset = 0, trip_event = 0;
  logic [7:0] poll_addr, poll_data, fan_speed0, fan_speed1;
  logic [1:0] poll_cpu;
  logic [3:0] fan_present = 4'hf, fan_fault = 4'h0, temp_critical = 4'h0;
  logic [7:0] fan_policy_speed0 = 8'h5a, fan_policy_speed1 = 8'h6b;
  int n_fail = 0, samples_checked = 0;
  health_monitor dut (.*);
  peci_poller_model poller (.*);
  initial forever #5 pclk = ~pclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic pulse(input bit pd, input string nm);
    bit hit = 0;
    repeat (8) begin
      @(posedge pclk);
      #1;
      if ((pd ? power_down_ok : cpu_missing_alert) === 1'b1) hit = 1;
    end
    chk(nm, 1, {31'h0, hit});
  endtask
  function automatic logic [31:0] spd();
    return {16'h0, fan_speed1, fan_speed0};
  endfunction
  task automatic t_reset();
    apb(0, 8'h04, 0);
    chk("cpu status", 32'h08010101, rd & 32'h0f0f0f0f);
    apb(0, 8'h14, 0);
    chk("limit", 32'h32, rd & 32'h7f);
    apb(0, 8'h40, 0);
    chk("unmapped", 1, {31'h0, er});
    $display("t_reset done");
  endtask
  task automatic t_internal_error_flag();
    internal_error_flag <= 4'h2;
    tick(3);
    internal_error_flag <= 4'h0;
    dc_power_on <= 1;
    system_reset <= 1;
    tick(3);
    system_reset <= 0;
    apb(0, 8'h04, 0);
    chk("internal_error_flag sticky", 32'h0400, rd & 32'h0400);
    apb(1, 8'h08, 32'h2);
    apb(0, 8'h04, 0);
    chk("rearm", 32'h2000, rd & 32'h2400);
    $display("t_internal_error_flag done");
  endtask
  task automatic t_trip();
    cpu_trip <= 4'h4;
    trip_event <= 1;
    pulse(1, "power down");
    trip_event <= 0;
    cpu_trip <= 4'h0;
    apb(0, 8'h04, 0);
    chk("trip", 32'h00120000, rd & 32'h12121212);
    apb(1, 8'h08, 32'h4);
    apb(0, 8'h04, 0);
    chk("retest", 0, rd & 32'h00120000);
    regulator_overtemp_signal <= 4'h9;
    cpu_throttle_in <= 4'h2;
    tick(2);
    chk("throttle", 32'hb, {28'h0, cpu_throttle_out});
    regulator_overtemp_signal <= 4'h0;
    cpu_throttle_in <= 4'h0;
    apb(1, 8'h00, 32'h8);
    tick(60);
    apb(0, 8'h0c, 0);
    chk("thermal", 32'hf000f000, rd);
    apb(1, 8'h00, 0);
    $display("t_trip done");
  endtask
  task automatic t_fans();
    chk("nominal", 32'h6b5a, spd());
    fan_present <= 4'hd;
    tick(4);
    chk("absent", 32'h6bff, spd());
    apb(0, 8'h18, 0);
    chk("fan status", 32'h00030200, rd & 32'h03030f00);
    fan_present <= 4'hf;
    tick(4);
    chk("reinsert", 32'h6b5a, spd());
    apb(1, 8'h00, 32'h3);
    tick(4);
    chk("sleep", 32'h3333, spd());
    fan_fault <= 4'h4;
    tick(4);
    chk("fault", 32'hff33, spd());
    apb(1, 8'h00, 32'h7);
    apb(1, 8'h20, 32'h00010011);
    tick(4);
    chk("force", 32'hff11, spd());
    apb(1, 8'h20, 0);
    apb(1, 8'h00, 0);
    $display("t_fans done");
  endtask
  task automatic t_missing();
    cpu_present <= 4'h0;
    dc_power_on <= 0;
    tick(2);
    dc_power_on <= 1;
    pulse(0, "missing alert");
    system_reset <= 1;
    tick(2);
    system_reset <= 0;
    apb(0, 8'h08, 0);
    chk("missing held", 1, rd & 32'h1);
    apb(0, 8'h04, 0);
    chk("empty", 32'h08080808, rd & 32'h0f0f0f0f);
    ac_power_on <= 0;
    tick(2);
    cpu_present <= 4'h1;
    tick(2);
    ac_power_on <= 1;
    apb(0, 8'h08, 0);
    chk("missing clear", 0, rd & 32'h1);
    $display("t_missing done");
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    tick(5);
    presetn <= 1;
    t_reset();
    t_internal_error_flag();
    t_trip();
    t_fans();
    t_missing();
    summarize();
  end
  // run needs well under a thousand cycles
  initial begin
    #100000;
    n_fail++;
    summarize();
  end
endmodule
